// [bofxm_regs.svh]
`ifndef BOFXM_REGS_SVH
`define BOFXM_REGS_SVH
// =====================================================
// register byte offsets
`define BOFXM_A_CMD 8'h00
`define BOFXM_A_SPC 8'h04
`define BOFXM_A_LEN 8'h08
`define BOFXM_A_DATA 8'h0C
`define BOFXM_A_ISR 8'h10
`define BOFXM_A_FSR 8'h14
`define BOFXM_A_RES 8'h18
// =====================================================
// command/control bits
`define BOFXM_CMD_ABORT 0
`define BOFXM_CMD_FIDLE 3
`define BOFXM_CMD_CRC 5
`define BOFXM_CMD_SRST 6
`define BOFXM_CMD_TXEN 7
// =====================================================
// serial port control and status fields
`define BOFXM_SPC_INV 0
`define BOFXM_ISR_VPS 4
`define BOFXM_FSR_EMPTY 0
`define BOFXM_FSR_FULL 1
`define BOFXM_FSR_BA 3
`define BOFXM_FSR_UND 4
// =====================================================
// line patterns, crc and sizes
`define BOFXM_FLAG 8'h7E
`define BOFXM_ABT 8'h7F
`define BOFXM_CRC_POLY 16'h8408
`define BOFXM_CRC_INIT 16'hFFFF
`define BOFXM_FIFO_FULL 5'h10
`define BOFXM_STUFF_RUN 3'h5
`define BOFXM_RST_CMD 8'h00
`endif

// [bofxm_pkg.sv]
package bofxm_pkg;
   // transmitter sequencing states
   typedef enum logic [2:0] {
      ST_MARK, ST_FIDLE, ST_OPEN, ST_DATA, ST_FCS, ST_CLOSE, ST_ABORT, ST_UNDER
   } bofxm_state_t;
   // all state of the transmitter
   typedef struct packed {
      bofxm_state_t st;
      logic [15:0][8:0] mem;
      logic [3:0] wp;
      logic [3:0] rp;
      logic [4:0] cnt;
      logic [15:0] tbcr;
      logic [15:0] tbc;
      logic [7:0] cmd;
      logic [5:0] spc;
      logic [2:0] res;
      logic vps;
      logic und;
      logic abt_pend;
      logic [7:0] sh;
      logic [3:0] bn;
      logic [2:0] blen;
      logic last;
      logic [2:0] ones;
      logic [15:0] crc;
      logic [2:0] clk_s;
      logic [1:0] fs_s;
      logic [7:0] slot;
      logic out;
      logic drv;
      logic [31:0] rdata;
   } bofxm_regs_t;
endpackage

// [bofxm_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bofxm_regs.svh"
// Overview of operation
// - insert a zero after five ones, opening flag to last check bit
// - flags, aborts and mark idle bypass the zero insertion
// - bytes go lsb first; check sequence sent in reverse order
// - hard or soft reset: disabled, mark idle state
// - disable only releases the serial pin; sequencing continues
// - byte counter tags the byte matching programmed length as last
// - idle until fifo has data, then opening flag, then data
// - data state shifts fifo bytes out of eight-bit shifter
// - output optionally inverted, one of 31 slots or unslotted
// - after data go to check state if crc on, else close
// - check state sends 16 bits, sets valid-sent bit, then close
// - one closing flag, then new frame if data, else idle
// - idle fill bit picks mark idle or flag idle
// - while abort bit set, repeat seven ones then zero
// - abort starts next bit; fifo, counter and length cleared
// - aborts repeat until bit cleared; out of frame at once
// - after abort: flag idle if selected or data, else mark
// - last byte may carry fewer bits per residual setting
// - inversion and channel never alter state sequence
// - check is inverted ccitt crc over unstuffed packet bits
// - every abort request sends at least one full abort char
// - empty fifo in frame: underrun flag, one abort, idle
// - fifo holds 16 entries of data byte plus last tag
module bofxm_top
   import bofxm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_bit_clk,
   input wire logic serial_frame_sync,
   output logic serial_line_out_o,
   output logic serial_line_out_oe,
   output logic tx_in_frame
);
   import bofxm_pkg::*;

   bofxm_regs_t q;
   bofxm_regs_t d;
   logic acc;
   logic wr;
   logic hit;
   logic strobe;
   logic abt;
   logic push;
   logic [7:0] pos;
   logic [4:0] ch;

   // =====================================================
   // bus decode and bit strobe
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign hit = (paddr <= `BOFXM_A_RES) && (paddr[1:0] == 2'h0);
   assign pready = 1'b1;
   assign pslverr = acc & ~hit;
   assign prdata = q.rdata;
   assign serial_line_out_o = q.out;
   assign serial_line_out_oe = q.drv;
   assign tx_in_frame = q.st inside {ST_OPEN, ST_DATA, ST_FCS, ST_CLOSE};
   assign abt = q.cmd[`BOFXM_CMD_ABORT] | q.abt_pend;
   assign push = wr && (paddr == `BOFXM_A_DATA) && (q.cnt != `BOFXM_FIFO_FULL);
   // slot position: frame sync marks slot 0, eight bit times per slot
   assign pos = q.fs_s[1] ? 8'h00 : q.slot + 8'h01;
   assign ch = q.spc[5:1];
   assign strobe = q.clk_s[1] & ~q.clk_s[2]
      & ((ch == 5'h00) | (pos[7:3] == ch - 5'h01));

   // =====================================================
   // helpers
   // abort and underrun both flush the fifo, counter and length
   function automatic bofxm_regs_t flush(input bofxm_regs_t s);
      bofxm_regs_t r;
      r = s;
      r.wp = 4'h0;
      r.rp = 4'h0;
      r.cnt = 5'h00;
      r.tbc = 16'h0000;
      r.tbcr = 16'h0000;
      r.bn = 4'h0;
      r.ones = 3'h0;
      return r;
   endfunction

   // take the next byte into the shifter, or report an underrun
   function automatic bofxm_regs_t fetch(input bofxm_regs_t s);
      bofxm_regs_t r;
      r = s;
      r.bn = 4'h0;
      if (s.cnt == 5'h00)
      begin
         r = flush(s);
         r.st = ST_UNDER;
         r.und = 1'b1;
      end
      else
      begin
         r.st = ST_DATA;
         r.sh = s.mem[s.rp][7:0];
         r.last = s.mem[s.rp][8];
         // residue only trims the tagged byte
         r.blen = (s.mem[s.rp][8] && s.res != 3'h0) ? s.res - 3'h1 : 3'h7;
         r.rp = s.rp + 4'h1;
         r.cnt = s.cnt - 5'h01;
      end
      return r;
   endfunction

   // =====================================================
   // next state
   always_comb
   begin
      logic b;
      logic stuff;
      logic [7:0] fl;
      logic [7:0] ab;
      b = 1'b1;
      stuff = 1'b0;
      fl = `BOFXM_FLAG;
      ab = `BOFXM_ABT;
      d = q;
      // pin synchronisers; stage 0 feeds stage 1 only
      d.clk_s = {q.clk_s[1], q.clk_s[0], serial_bit_clk};
      d.fs_s = {q.fs_s[0], serial_frame_sync};
      if (q.clk_s[1] & ~q.clk_s[2])
         d.slot = pos;
      // read data captured in setup phase, valid through access
      if (psel & ~penable)
      begin
         unique case (paddr)
            `BOFXM_A_CMD: d.rdata = {24'h0, q.cmd};
            `BOFXM_A_SPC: d.rdata = {26'h0, q.spc};
            `BOFXM_A_LEN: d.rdata = {16'h0, q.tbcr};
            `BOFXM_A_ISR: d.rdata = {27'h0, q.vps, 4'h0};
            `BOFXM_A_FSR: d.rdata = {19'h0, q.cnt, 3'h0, q.und,
               (q.cnt == 5'h00), 1'b0, (q.cnt == `BOFXM_FIFO_FULL), (q.cnt == 5'h00)};
            `BOFXM_A_RES: d.rdata = {29'h0, q.res};
            default: d.rdata = 32'h0;
         endcase
      end
      // register writes take effect at the access edge
      if (wr && paddr == `BOFXM_A_CMD)
      begin
         d.cmd = pwdata[7:0] & 8'hBF;
         // latch the request so a quick set-clear still aborts
         if (pwdata[`BOFXM_CMD_ABORT])
            d.abt_pend = 1'b1;
      end
      if (wr && paddr == `BOFXM_A_SPC)
         d.spc = pwdata[5:0];
      if (wr && paddr == `BOFXM_A_RES)
         d.res = pwdata[2:0];
      if (wr && paddr == `BOFXM_A_LEN)
      begin
         d.tbcr = pwdata[15:0];
         if (!tx_in_frame)
            d.tbc = pwdata[15:0];
      end
      if (wr && paddr == `BOFXM_A_ISR && pwdata[`BOFXM_ISR_VPS])
         d.vps = 1'b0;
      if (wr && paddr == `BOFXM_A_FSR && pwdata[`BOFXM_FSR_UND])
         d.und = 1'b0;
      // fifo load: counter tags the byte that ends the packet
      if (push)
      begin
         d.mem[q.wp] = {(q.tbc <= 16'h0001), pwdata[7:0]};
         d.tbc = (q.tbc <= 16'h0001) ? q.tbcr : q.tbc - 16'h0001;
         d.wp = q.wp + 4'h1;
         d.cnt = q.cnt + 5'h01;
      end
      // line bit for the current state
      unique case (q.st)
         ST_MARK: b = 1'b1;
         ST_FIDLE, ST_OPEN, ST_CLOSE: b = fl[q.bn[2:0]];
         ST_ABORT, ST_UNDER: b = ab[q.bn[2:0]];
         ST_DATA:
         begin
            stuff = (q.ones == `BOFXM_STUFF_RUN);
            b = stuff ? 1'b0 : q.sh[0];
         end
         ST_FCS:
         begin
            stuff = (q.ones == `BOFXM_STUFF_RUN);
            b = stuff ? 1'b0 : ~q.crc[0];
         end
      endcase
      // sequencing advances once per bit strobe
      if (strobe)
      begin
         d.out = b ^ q.spc[`BOFXM_SPC_INV];
         d.bn = q.bn + 4'h1;
         if (q.st inside {ST_DATA, ST_FCS})
         begin
            d.bn = stuff ? q.bn : q.bn + 4'h1;
            d.ones = (stuff | ~b) ? 3'h0 : q.ones + 3'h1;
         end
         if (abt && q.st != ST_ABORT)
         begin
            d = flush(d);
            d.st = ST_ABORT;
            d.abt_pend = 1'b0;
         end
         else
         begin
            unique case (q.st)
               ST_MARK:
               begin
                  if (q.cnt != 5'h00)
                     d.st = ST_OPEN;
                  else if (q.cmd[`BOFXM_CMD_FIDLE])
                     d.st = ST_FIDLE;
                  d.bn = 4'h0;
               end
               ST_FIDLE:
               begin
                  if (q.bn[2:0] == 3'h7 && q.cnt != 5'h00)
                     d.st = ST_OPEN;
                  else if (q.bn[2:0] == 3'h7 && !q.cmd[`BOFXM_CMD_FIDLE])
                     d.st = ST_MARK;
                  d.bn = {1'b0, d.bn[2:0]};
               end
               ST_OPEN:
               begin
                  if (q.bn[2:0] == 3'h7)
                  begin
                     d = fetch(d);
                     d.crc = `BOFXM_CRC_INIT;
                     d.ones = 3'h0;
                  end
               end
               ST_DATA:
               begin
                  if (!stuff)
                  begin
                     // reflected ccitt crc over the unstuffed bit
                     d.crc = {1'b0, q.crc[15:1]}
                        ^ ((q.crc[0] ^ q.sh[0]) ? `BOFXM_CRC_POLY : 16'h0000);
                     d.sh = {1'b0, q.sh[7:1]};
                     if (q.bn[2:0] == q.blen)
                     begin
                        if (q.last)
                        begin
                           d.bn = 4'h0;
                           d.st = q.cmd[`BOFXM_CMD_CRC] ? ST_FCS : ST_CLOSE;
                        end
                        else
                           d = fetch(d);
                     end
                  end
               end
               ST_FCS:
               begin
                  if (!stuff)
                  begin
                     d.crc = {1'b1, q.crc[15:1]};
                     if (q.bn == 4'hF)
                     begin
                        d.st = ST_CLOSE;
                        d.vps = 1'b1;
                     end
                  end
               end
               ST_CLOSE:
               begin
                  if (q.bn[2:0] == 3'h7)
                  begin
                     d.bn = 4'h0;
                     if (q.cnt != 5'h00)
                        d.st = ST_OPEN;
                     else
                        d.st = q.cmd[`BOFXM_CMD_FIDLE] ? ST_FIDLE : ST_MARK;
                  end
               end
               ST_ABORT:
               begin
                  d.bn = {1'b0, d.bn[2:0]};
                  if (q.bn[2:0] == 3'h7 && !abt)
                  begin
                     // data waiting goes out behind flags
                     d.st = (q.cmd[`BOFXM_CMD_FIDLE] || q.cnt != 5'h00) ? ST_FIDLE : ST_MARK;
                  end
               end
               ST_UNDER:
               begin
                  if (q.bn[2:0] == 3'h7)
                  begin
                     d.bn = 4'h0;
                     d.st = q.cmd[`BOFXM_CMD_FIDLE] ? ST_FIDLE : ST_MARK;
                  end
               end
            endcase
         end
      end
      // pin released only once the frame is over
      if (!tx_in_frame || q.cmd[`BOFXM_CMD_TXEN])
         d.drv = q.cmd[`BOFXM_CMD_TXEN];
      // software reset outranks everything in this cycle
      if (wr && paddr == `BOFXM_A_CMD && pwdata[`BOFXM_CMD_SRST])
      begin
         d = flush(d);
         d.st = ST_MARK;
         d.cmd = `BOFXM_RST_CMD;
         d.abt_pend = 1'b0;
         d.drv = 1'b0;
      end
   end

   // =====================================================
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.st <= ST_MARK;
         q.crc <= `BOFXM_CRC_INIT;
         q.out <= 1'b1;
      end
      else
         q <= d;
   end

   // =====================================================
   // checks
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic srst;
   assign srst = wr && paddr == `BOFXM_A_CMD && pwdata[`BOFXM_CMD_SRST];

   sequence s_abt_go;
      strobe && abt && q.st != ST_ABORT && !srst;
   endsequence

   sequence s_abt_in;
      q.st == ST_ABORT && q.cnt == 5'h00 && q.tbcr == 16'h0000 && !tx_in_frame;
   endsequence

   stuff_zero_a: assert property (
      strobe && q.st inside {ST_DATA, ST_FCS} && q.ones == 3'h5 && !srst && !abt
      |=> q.out == q.spc[0] && q.bn == $past(q.bn))
      else $error("no zero stuffed after five ones");

   flag_bits_a: assert property (
      strobe && q.st == ST_OPEN && q.bn == 4'h1
      |=> q.out == ~q.spc[0])
      else $error("opening flag bit one wrong");

   soft_reset_a: assert property (
      srst |=> q.st == ST_MARK && q.cmd == 8'h00 && !q.drv)
      else $error("soft reset did not idle transmitter");

   pin_release_a: assert property (
      $fell(q.drv) |-> !$past(tx_in_frame) || $past(srst))
      else $error("pin released inside a frame");

   last_tag_a: assert property (
      push && q.tbc == 16'h0001 && !srst |=> q.mem[$past(q.wp)][8] && q.tbc == q.tbcr)
      else $error("last byte not tagged");

   open_go_a: assert property (
      strobe && q.st == ST_MARK && q.cnt != 5'h00 && !abt && !srst |=> q.st == ST_OPEN)
      else $error("idle did not open a frame");

   crc_path_a: assert property (
      $past(q.st) == ST_DATA && q.st inside {ST_FCS, ST_CLOSE}
      |-> (q.st == ST_FCS) == q.cmd[`BOFXM_CMD_CRC])
      else $error("wrong state after packet data");

   abort_go_a: assert property (
      s_abt_go |=> s_abt_in)
      else $error("abort entry did not clear fifo");

   abort_hold_a: assert property (
      q.st == ST_ABORT && q.cmd[0] && !srst |=> q.st == ST_ABORT)
      else $error("left abort while requested");

   under_flag_a: assert property (
      q.st != ST_UNDER ##1 q.st == ST_UNDER |-> q.und && q.cnt == 5'h00)
      else $error("underrun not flagged");
endmodule // bofxm_top
`default_nettype wire

// [bofxm_link_partner.sv]
`timescale 1ns/10ps
`default_nettype none
// =====
// far-end receiver: makes the line bit clock and records every bit
module bofxm_link_partner
(
   input wire logic line_o,
   input wire logic line_oe,
   output logic bit_clk,
   output logic frame_sync
);
   logic bits[$];
   int n = 0;
   // free-running bit clock, phase unrelated to pclk
   initial
   begin
      bit_clk = 1'b0;
      forever #320 bit_clk = ~bit_clk; // one strobe per line bit
   end
   // sync marks bit 0 of slot 0 every 248 bits
   always @(posedge bit_clk)
   begin
      n = (n == 247) ? 0 : n + 1;
      frame_sync <= (n == 0);
   end
   // sample mid-bit; a released pin reads high through the pull-up
   always @(negedge bit_clk)
      bits.push_back(line_oe ? line_o : 1'b1);
endmodule // bofxm_link_partner
`default_nettype wire

// [bofxm_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bofxm_regs.svh"
module bofxm_top_tb;
   import bofxm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic line_o, line_oe, tx_in_frame;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   wire logic bit_clk;
   wire logic fsync;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int ones;
   logic exp[$];
   logic [15:0] crc;
   // =====
   // design and far end
   bofxm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_bit_clk(bit_clk), .serial_frame_sync(fsync),
      .serial_line_out_o(line_o), .serial_line_out_oe(line_oe), .tx_in_frame(tx_in_frame));
   bofxm_link_partner partner_u (.line_o(line_o), .line_oe(line_oe), .bit_clk(bit_clk),
      .frame_sync(fsync));
   // 25 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // hang guard, well above the expected run length
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         stop_test();
      end
   end
   // =====
   // shared tasks
   task stop_test;
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask
   // request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_bits(input int n);
      repeat (n) @(negedge bit_clk);
   endtask
   task wait_frame;
      while (tx_in_frame !== 1'b1)
         @(posedge pclk);
      while (tx_in_frame === 1'b1)
         @(posedge pclk);
   endtask
   task add_bit(input logic b, input logic stuff);
      exp.push_back(b);
      ones = b ? ones + 1 : 0;
      if (stuff && ones == 5)
      begin
         exp.push_back(1'b0); // zero after five ones
         ones = 0;
      end
   endtask
   // flags go unstuffed and outside the crc
   task add_byte(input logic [7:0] b, input logic stuff, input int nb);
      for (int i = 0; i < nb; i++)
      begin
         add_bit(b[i], stuff); // lsb first
         crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? 16'h8408 : 16'h0000);
      end
   endtask
   task expect_abort(input string what);
      logic [7:0] seen;
      int z;
      // the first zero with seven bits before it closes a whole character
      z = 7;
      while (z < partner_u.bits.size() && partner_u.bits[z] !== 1'b0)
         z++;
      for (int i = 0; i < 8; i++)
         seen[i] = partner_u.bits[z - 7 + i];
      chk(what, seen, 8'h7F);
   endtask
   // =====
   // scenarios
   task t_reset;
      chk("oe_reset", line_oe, 1'b0);
      chk("frame_reset", tx_in_frame, 1'b0);
      apb(1'b0, `BOFXM_A_CMD, 32'h0);
      chk("cmd_reset", rdata, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped_err", rerr, 1'b1);
      apb(1'b1, `BOFXM_A_CMD, 32'h80);
      wait_bits(4);
      partner_u.bits.delete();
      wait_bits(16);
      chk("mark_idle", line_oe & partner_u.bits.and(), 1'b1);
   endtask
   task t_frame(input logic crc_en, input logic inv, input logic fid, input logic [2:0] res);
      logic [7:0] pkt [3];
      logic [15:0] fcs;
      int hit;
      int k;
      pkt = '{8'hFF, 8'h3E, 8'h81};
      apb(1'b1, `BOFXM_A_SPC, {31'h0, inv});
      apb(1'b1, `BOFXM_A_CMD, {24'h0, 2'b10, crc_en, 1'b0, fid, 3'h0});
      apb(1'b1, `BOFXM_A_LEN, 32'h3);
      apb(1'b1, `BOFXM_A_RES, {29'h0, res});
      wait_bits(4);
      partner_u.bits.delete();
      foreach (pkt[i])
         apb(1'b1, `BOFXM_A_DATA, {24'h0, pkt[i]});
      wait_frame();
      wait_bits(12);
      // expected line: flag, stuffed bytes, check bits, flag, idle fill
      exp.delete();
      ones = 0;
      add_byte(`BOFXM_FLAG, 1'b0, 8);
      crc = 16'hFFFF;
      // a nonzero residue trims the last packet byte to that many bits
      foreach (pkt[i])
         add_byte(pkt[i], 1'b1, (i == 2 && res != 3'h0) ? int'(res) : 8);
      fcs = ~crc;
      if (crc_en)
      begin
         add_byte(fcs[7:0], 1'b1, 8);
         add_byte(fcs[15:8], 1'b1, 8);
      end
      add_byte(`BOFXM_FLAG, 1'b0, 8);
      add_byte(fid ? `BOFXM_FLAG : 8'hFF, 1'b0, 8);
      hit = 0;
      for (int s = 0; s + exp.size() <= partner_u.bits.size(); s++)
      begin
         k = 0;
         while (k < exp.size() && (partner_u.bits[s + k] ^ inv) === exp[k])
            k++;
         if (k == exp.size())
            hit = 1;
      end
      chk("frame_bits", hit, 1);
      apb(1'b0, `BOFXM_A_ISR, 32'h0);
      chk("valid_sent", rdata, {27'h0, crc_en, 4'h0});
      apb(1'b1, `BOFXM_A_ISR, 32'h10);
   endtask
   task t_abort;
      apb(1'b1, `BOFXM_A_SPC, 32'h0);
      apb(1'b1, `BOFXM_A_CMD, 32'h80);
      apb(1'b1, `BOFXM_A_LEN, 32'h4);
      repeat (4) apb(1'b1, `BOFXM_A_DATA, 32'h5A);
      while (tx_in_frame !== 1'b1)
         @(posedge pclk);
      wait_bits(10);
      apb(1'b1, `BOFXM_A_CMD, 32'h81);
      wait_bits(2);
      chk("abort_frame", tx_in_frame, 1'b0);
      partner_u.bits.delete();
      wait_bits(20);
      expect_abort("abort_char");
      apb(1'b0, `BOFXM_A_FSR, 32'h0);
      chk("abort_fifo", rdata & 32'h1F01, 32'h1);
      apb(1'b0, `BOFXM_A_LEN, 32'h0);
      chk("abort_len", rdata, 32'h0);
      apb(1'b1, `BOFXM_A_CMD, 32'h80);
      wait_bits(12);
      partner_u.bits.delete();
      wait_bits(16);
      chk("abort_mark", partner_u.bits.and(), 1'b1);
      // set and cleared at once still sends a whole character
      partner_u.bits.delete();
      apb(1'b1, `BOFXM_A_CMD, 32'h81);
      apb(1'b1, `BOFXM_A_CMD, 32'h80);
      wait_bits(24);
      expect_abort("abort_short");
   endtask
   task t_underrun;
      apb(1'b1, `BOFXM_A_LEN, 32'h3);
      apb(1'b1, `BOFXM_A_DATA, 32'hA5);
      wait_frame();
      apb(1'b0, `BOFXM_A_FSR, 32'h0);
      chk("underrun_flag", rdata & 32'h10, 32'h10);
      apb(1'b0, `BOFXM_A_LEN, 32'h0);
      chk("underrun_len", rdata, 32'h0);
   endtask
   task t_soft_reset;
      apb(1'b1, `BOFXM_A_CMD, 32'hA8);
      apb(1'b1, `BOFXM_A_CMD, 32'h40);
      apb(1'b0, `BOFXM_A_CMD, 32'h0);
      chk("srst_cmd", rdata, 32'h0);
      wait_bits(2);
      chk("srst_oe", line_oe, 1'b0);
   endtask
   // =====
   // main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_frame(1'b1, 1'b1, 1'b0, 3'h0);
      t_frame(1'b0, 1'b0, 1'b1, 3'h0);
      t_frame(1'b1, 1'b0, 1'b0, 3'h3);
      t_abort();
      t_underrun();
      t_soft_reset();
      stop_test();
   end
endmodule // bofxm_top_tb
`default_nettype wire
